//--- hw/cis_cache_invalidate_op_seq.sv
// slave-write sequencer that displays a cache-invalidate operation
// assumes req is a level held by the core until done pulses
`timescale 1ns/100ps
`default_nettype none
module cis_cache_invalidate_op_seq
  import cis_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset,
  cis_sp_if.seq     sp
);

  cis_cv_e state_r;
  cis_cv_e state_nxt;
  logic [DATA_W-1:0] opnd_r;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CV_IDLE: if (sp.req) state_nxt = CV_OPC;
      CV_OPC:  state_nxt = CV_OPND;
      CV_OPND: state_nxt = CV_DONE;
      CV_DONE: if (!sp.req) state_nxt = CV_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= CV_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // operand captured with the request so a changing core bus is harmless
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      opnd_r <= '0;
    end else if (state_r == CV_IDLE && sp.req) begin
      opnd_r <= sp.operand;
    end
  end

  // busy looks ahead one state so the registered status code shows the
  // slave write in the same cycle as the strobe and data
  assign sp.busy = (state_nxt == CV_OPC) || (state_nxt == CV_OPND);

  // ----------------------------------------------------------------
  // slave write cycles: opcode first, then operand
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sp.wr_stb  <= 1'b0;
      sp.wr_data <= '0;
      sp.done    <= 1'b0;
    end else begin
      sp.wr_stb  <= (state_nxt == CV_OPC) || (state_nxt == CV_OPND);
      sp.done    <= (state_r == CV_OPND);
      if (state_nxt == CV_OPC) begin
        sp.wr_data <= DATA_W'(sp.opcode);
      end else if (state_nxt == CV_OPND) begin
        sp.wr_data <= opnd_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_opc_cycle;
    sp.wr_stb && sp.wr_data == DATA_W'($past(sp.opcode));
  endsequence

  sequence s_opnd_cycle;
    sp.wr_stb && sp.wr_data == $past(opnd_r);
  endsequence

  a_cache_invalidate_op_two_writes: assert property (@(posedge mclk) disable iff (reset)
    (state_r == CV_IDLE && sp.req) |=> s_opc_cycle ##1 s_opnd_cycle ##1 !sp.wr_stb)
    else $error("cache invalidate not shown as two slave writes");

endmodule
`default_nettype wire

//--- hw/cis_status_top.sv
// internal-status outputs: privilege, instruction start, breakpoint,
// idle status codes and cache-invalidate display
// assumes all core inputs are synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module cis_status_top
  import cis_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                psr_user,
  input  wire logic                move_to_user_space,
  input  wire logic                move_to_supervisor_space,
  input  wire logic                op_src_read,
  input  wire logic                op_dst_write,
  input  wire logic                instr_begin,
  input  wire logic [3:0]          flow_kind,
  input  wire logic                branch_taken,
  input  wire logic                addr_cmp_hit,
  input  wire logic                pc_match_hit,
  input  wire logic                cache_invalidate_op_req,
  input  wire logic [OPCODE_W-1:0] cache_invalidate_op_opcode,
  input  wire logic [DATA_W-1:0]   cache_invalidate_op_operand,
  input  wire logic                bus_idle,
  input  wire logic                wait_interrupt,
  input  wire logic                wait_slave,
  input  wire logic                halted,
  input  wire logic [STATUS_W-1:0] core_status,
  output logic                     user_mode_r,
  output logic                     instruction_start_pulse_r,
  output logic                     nonsequential_flag_r,
  output logic                     breakpoint_hit_r,
  output logic [STATUS_W-1:0]      bus_status_code_r,
  output logic                     slave_write_stb,
  output logic [DATA_W-1:0]        slave_write_data,
  output logic                     cache_invalidate_op_done
);

  // ----------------------------------------------------------------
  // flow classification
  // ----------------------------------------------------------------
  function automatic logic flow_breaks(input logic [3:0] kind,
                                       input logic       taken);
    logic r;
    r = 1'b1;
    unique case (cis_flow_e'(kind))
      FLOW_SEQ:        r = 1'b0;
      FLOW_ADD_CMP_BR: r = taken;
      FLOW_COND_BR:    r = taken;
      default:         r = 1'b1;
    endcase
    return r;
  endfunction

  logic nonseq_now;
  logic force_user;
  logic addr_pend_r;
  logic pc_pend_r;
  logic addr_slot;
  logic pc_slot;
  logic addr_take;
  logic pc_take;
  logic [STATUS_W-1:0] status_nxt;

  assign nonseq_now = flow_breaks(flow_kind, branch_taken);
  assign force_user = (move_to_user_space && op_src_read)
                   || (move_to_supervisor_space && op_dst_write);

  // ----------------------------------------------------------------
  // privilege indicator
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      user_mode_r <= 1'b0;
    end else begin
      user_mode_r <= force_user ? 1'b1 : psr_user;
    end
  end

  // ----------------------------------------------------------------
  // instruction start and nonsequential flag
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      instruction_start_pulse_r <= 1'b0;
      nonsequential_flag_r      <= 1'b0;
    end else begin
      instruction_start_pulse_r <= instr_begin;
      nonsequential_flag_r      <= instr_begin && nonseq_now;
    end
  end

  // ----------------------------------------------------------------
  // breakpoint scheduling
  // ----------------------------------------------------------------
  // an address-compare hit waits for the cycle right after a start
  // pulse; a pc-match hit avoids that cycle and the one before it so
  // external logic can tell the two apart by position alone
  assign addr_slot = instruction_start_pulse_r;
  assign pc_slot   = !instruction_start_pulse_r && !instr_begin
                  && !breakpoint_hit_r;
  assign addr_take = addr_slot && addr_pend_r;
  assign pc_take   = pc_slot && pc_pend_r;

  // new detections win over the clear of the same cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addr_pend_r <= 1'b0;
    end else if (addr_cmp_hit) begin
      addr_pend_r <= 1'b1;
    end else if (addr_take) begin
      addr_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pc_pend_r <= 1'b0;
    end else if (pc_match_hit) begin
      pc_pend_r <= 1'b1;
    end else if (pc_take) begin
      pc_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      breakpoint_hit_r <= 1'b0;
    end else begin
      breakpoint_hit_r <= addr_take || pc_take;
    end
  end

  // ----------------------------------------------------------------
  // cache-invalidate display
  // ----------------------------------------------------------------
  cis_sp_if sp ();

  assign sp.req     = cache_invalidate_op_req;
  assign sp.opcode  = cache_invalidate_op_opcode;
  assign sp.operand = cache_invalidate_op_operand;

  cis_cache_invalidate_op_seq u_cache_invalidate_op (
    .mclk  (mclk),
    .reset (reset),
    .sp    (sp.seq)
  );

  assign slave_write_stb  = sp.wr_stb;
  assign slave_write_data = sp.wr_data;
  assign cache_invalidate_op_done        = sp.done;

  // ----------------------------------------------------------------
  // bus status code
  // ----------------------------------------------------------------
  // halt outranks the waits; a slave write outranks idle because the
  // bus is then really carrying a cycle
  always_comb begin
    status_nxt = core_status;
    if (sp.busy) begin
      status_nxt = ST_SLAVE_WRITE;
    end else if (bus_idle) begin
      if (halted) begin
        status_nxt = ST_HALTED;
      end else if (wait_slave) begin
        status_nxt = ST_WAIT_SLAVE;
      end else if (wait_interrupt) begin
        status_nxt = ST_WAIT_INT;
      end else begin
        status_nxt = ST_IDLE_PLAIN;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus_status_code_r <= ST_RESET_VAL;
    end else begin
      bus_status_code_r <= status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_priv_mirror: assert property (
    !force_user |=> user_mode_r == $past(psr_user))
    else $error("privilege output does not follow state word");

  a_priv_user_move: assert property (
    move_to_user_space && op_src_read && !psr_user |=> user_mode_r)
    else $error("privilege not forced on user-space source read");

  a_priv_sup_move: assert property (
    move_to_supervisor_space && op_dst_write |=> user_mode_r)
    else $error("privilege not forced on supervisor-space write");

  a_start_single: assert property (
    instr_begin ##1 !instr_begin |-> instruction_start_pulse_r ##1
      !instruction_start_pulse_r)
    else $error("start pulse is not one clock wide");

  a_nonseq_with_start: assert property (
    nonsequential_flag_r |-> instruction_start_pulse_r)
    else $error("nonsequential flag without start pulse");

  a_nonseq_taken: assert property (
    instr_begin && cis_flow_e'(flow_kind) == FLOW_COND_BR && branch_taken
      |=> nonsequential_flag_r)
    else $error("taken branch not flagged nonsequential");

  a_seq_low: assert property (
    instr_begin && cis_flow_e'(flow_kind) == FLOW_SEQ |=> !nonsequential_flag_r)
    else $error("sequential start flagged nonsequential");

  sequence s_addr_armed;
    instruction_start_pulse_r && addr_pend_r;
  endsequence

  a_addr_slot: assert property (
    s_addr_armed |=> breakpoint_hit_r)
    else $error("address-compare hit missed its slot");

  a_pc_off_slot: assert property (
    breakpoint_hit_r && $past(instruction_start_pulse_r) |-> $past(addr_pend_r))
    else $error("pc-match hit placed in address-compare slot");

  a_pc_deliver: assert property (
    pc_pend_r && pc_slot |=> breakpoint_hit_r ##1 !breakpoint_hit_r)
    else $error("pc-match hit not a single clock pulse");

  a_idle_halt: assert property (
    bus_idle && halted && !sp.busy |=> bus_status_code_r == ST_HALTED)
    else $error("halted idle cycle shows wrong status");

  a_idle_wait_int: assert property (
    bus_idle && wait_interrupt && !halted && !wait_slave && !sp.busy
      |=> bus_status_code_r == ST_WAIT_INT)
    else $error("interrupt wait shows wrong status");

endmodule
`default_nettype wire

//--- inc/cis_pkg.sv
// constants shared by the internal-status output block
// assumes a single 40 MHz bus clock domain and a synchronous core
package cis_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned STATUS_W  = 5;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned OPCODE_W  = 8;

  // ----------------------------------------------------------------
  // bus status codes shown on idle and slave-write cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] ST_IDLE_PLAIN  = 5'h00;
  localparam logic [4:0] ST_WAIT_INT    = 5'h01;
  localparam logic [4:0] ST_WAIT_SLAVE  = 5'h02;
  localparam logic [4:0] ST_HALTED      = 5'h03;
  localparam logic [4:0] ST_SLAVE_WRITE = 5'h04;
  localparam logic [4:0] ST_RESET_VAL   = 5'h00;

  // ----------------------------------------------------------------
  // program-flow kind of the instruction that is starting
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    FLOW_SEQ        = 4'h0,
    FLOW_EXCEPTION  = 4'h1,
    FLOW_ADD_CMP_BR = 4'h2,
    FLOW_COND_BR    = 4'h3,
    FLOW_PLAIN_JUMP = 4'h4,
    FLOW_SUB_CALL   = 4'h5,
    FLOW_CASE_BR    = 4'h6,
    FLOW_EXT_CALL   = 4'h7,
    FLOW_TRACE_MARK = 4'h8,
    FLOW_JUMP_SUB   = 4'h9,
    FLOW_JUMP       = 4'ha,
    FLOW_PROC_EXIT  = 4'hb,
    FLOW_TRAP_EXIT  = 4'hc
  } cis_flow_e;

  // ----------------------------------------------------------------
  // cache-invalidate sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CV_IDLE  = 4'b0001,
    CV_OPC   = 4'b0010,
    CV_OPND  = 4'b0100,
    CV_DONE  = 4'b1000
  } cis_cv_e;

endpackage

//--- inc/cis_sp_if.sv
// carrier between the status block and its slave-write sequencer
// assumes both ends share mclk
`timescale 1ns/100ps
`default_nettype none
interface cis_sp_if
  import cis_pkg::*;
  ();
  logic                req;
  logic [OPCODE_W-1:0] opcode;
  logic [DATA_W-1:0]   operand;
  logic                busy;
  logic                done;
  logic                wr_stb;
  logic [DATA_W-1:0]   wr_data;

  modport ctl (output req, output opcode, output operand,
               input busy, input done, input wr_stb, input wr_data);
  modport seq (input req, input opcode, input operand,
               output busy, output done, output wr_stb, output wr_data);
endinterface
`default_nettype wire

//--- verif/cis_trace_mon.sv
// external trace logic that sorts breakpoint pulses by kind
// assumes start and bp are registered outputs of the status block on mclk
`timescale 1ns/100ps
`default_nettype none
module cis_trace_mon (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic       bp,
  output logic [7:0]      addr_hits,
  output logic [7:0]      pc_hits
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic start_d_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      start_d_r <= 1'b0;
      addr_hits <= 8'h00;
      pc_hits   <= 8'h00;
    end else begin
      start_d_r <= start;
      if (bp && start_d_r) begin
        addr_hits <= addr_hits + 8'h01;
      end else if (bp) begin
        pc_hits <= pc_hits + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_cis_status_top.sv
// self-checking bench for the internal-status outputs
// assumes the design answers one mclk after it samples its inputs
`timescale 1ns/100ps
`default_nettype none
module tb_cis_status_top
  import cis_pkg::*;
;
  logic mclk = 1'b0, reset = 1'b1, psr_user = 1'b0, mus = 1'b0, msu = 1'b0;
  logic src_rd = 1'b0, dst_wr = 1'b0, ibeg = 1'b0, taken = 1'b0;
  logic ahit = 1'b0, phit = 1'b0, creq = 1'b0, idle = 1'b0;
  logic wint = 1'b0, wsl = 1'b0, hlt = 1'b0;
  logic [3:0]  flow = 4'h0;
  logic [7:0]  opc = 8'h00;
  logic [31:0] opnd = 32'h0;
  logic [4:0]  cst = 5'h00;
  logic        um, st, ns, bp, stb, done;
  logic [4:0]  sc;
  logic [31:0] wd;
  logic [7:0]  n_addr, n_pc;
  int          failures = 0, n_compared = 0, cycles = 0;

  cis_status_top cis_status_top_inst (.mclk(mclk), .reset(reset), .psr_user(psr_user),
    .move_to_user_space(mus), .move_to_supervisor_space(msu), .op_src_read(src_rd),
    .op_dst_write(dst_wr), .instr_begin(ibeg), .flow_kind(flow), .branch_taken(taken),
    .addr_cmp_hit(ahit), .pc_match_hit(phit), .cache_invalidate_op_req(creq), .cache_invalidate_op_opcode(opc),
    .cache_invalidate_op_operand(opnd), .bus_idle(idle), .wait_interrupt(wint), .wait_slave(wsl),
    .halted(hlt), .core_status(cst), .user_mode_r(um), .instruction_start_pulse_r(st),
    .nonsequential_flag_r(ns), .breakpoint_hit_r(bp), .bus_status_code_r(sc),
    .slave_write_stb(stb), .slave_write_data(wd), .cache_invalidate_op_done(done));

  cis_trace_mon cis_trace_mon_inst (.mclk(mclk), .reset(reset), .start(st), .bp(bp),
    .addr_hits(n_addr), .pc_hits(n_pc));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // a hang must still end in the verdict, so the cap counts as a mismatch
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic priv(input logic p, m_u, m_s, rd, wr, exp);
    @(posedge mclk);
    psr_user <= p;
    mus <= m_u;
    msu <= m_s;
    src_rd <= rd;
    dst_wr <= wr;
    tick();
    chk({31'h0, um}, {31'h0, exp});
  endtask

  task automatic t_priv();
    priv(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    priv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    priv(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    priv(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    priv(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    priv(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    priv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("t_priv done");
  endtask

  // every flow kind, each with taken low and high, back to back
  task automatic t_start();
    logic e;
    for (int k = 0; k < 13; k++) begin
      for (int t = 0; t < 2; t++) begin
        e = (k == FLOW_SEQ) ? 1'b0 : (k == FLOW_ADD_CMP_BR || k == FLOW_COND_BR) ? t[0] : 1'b1;
        @(posedge mclk);
        ibeg <= 1'b1;
        flow <= k[3:0];
        taken <= t[0];
        tick();
        chk({31'h0, st}, 32'h1);
        chk({31'h0, ns}, {31'h0, e});
      end
    end
    @(posedge mclk);
    ibeg <= 1'b0;
    tick();
    chk({31'h0, st}, 32'h0);
    $display("t_start done");
  endtask

  task automatic t_bp();
    @(posedge mclk);
    ahit <= 1'b1;
    ibeg <= 1'b1;
    flow <= FLOW_SEQ;
    @(posedge mclk);
    ahit <= 1'b0;
    ibeg <= 1'b0;
    #1;
    chk({31'h0, bp}, 32'h0);
    tick();
    chk({31'h0, bp}, 32'h1);
    @(posedge mclk);
    phit <= 1'b1;
    #1;
    chk({31'h0, bp}, 32'h0);
    @(posedge mclk);
    phit <= 1'b0;
    tick();
    chk({31'h0, bp}, 32'h1);
    tick();
    chk({31'h0, bp}, 32'h0);
    tick();
    chk({24'h0, n_addr}, 32'h1);
    chk({24'h0, n_pc}, 32'h1);
    $display("t_bp done");
  endtask

  task automatic t_cache_invalidate_op();
    @(posedge mclk);
    creq <= 1'b1;
    opc <= 8'ha5;
    opnd <= 32'hc0de_1234;
    cst <= 5'h1b;
    tick();
    chk({31'h0, stb}, 32'h1);
    chk(wd, 32'h0000_00a5);
    chk({27'h0, sc}, {27'h0, ST_SLAVE_WRITE});
    tick();
    chk({31'h0, stb}, 32'h1);
    chk(wd, 32'hc0de_1234);
    tick();
    chk({31'h0, done}, 32'h1);
    chk({31'h0, stb}, 32'h0);
    chk({27'h0, sc}, 32'h1b);
    @(posedge mclk);
    creq <= 1'b0;
    tick();
    chk({31'h0, done}, 32'h0);
    $display("t_cache_invalidate_op done");
  endtask

  task automatic idl(input logic i, h, s, w, input logic [4:0] exp);
    @(posedge mclk);
    idle <= i;
    hlt <= h;
    wsl <= s;
    wint <= w;
    tick();
    chk({27'h0, sc}, {27'h0, exp});
  endtask

  task automatic t_idle();
    idl(1'b1, 1'b1, 1'b1, 1'b1, ST_HALTED);
    idl(1'b1, 1'b0, 1'b1, 1'b1, ST_WAIT_SLAVE);
    idl(1'b1, 1'b0, 1'b0, 1'b1, ST_WAIT_INT);
    idl(1'b1, 1'b0, 1'b0, 1'b0, ST_IDLE_PLAIN);
    idl(1'b0, 1'b1, 1'b0, 1'b0, 5'h1b);
    $display("t_idle done");
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    t_priv();
    t_start();
    t_bp();
    t_cache_invalidate_op();
    t_idle();
    close_out();
  end
endmodule
`default_nettype wire
